// *** logic/fram_link_pkg.sv ***
// Shared constants and types for the two-wire memory link
package fram_link_pkg;

	// ----------------------------------------
	// Memory geometry
	// ----------------------------------------
	localparam int ADDR_W = 17; // Word address width
	localparam int MEM_DEPTH = 131072; // Bytes of storage
	localparam int BYTE_BITS = 8; // Bits per byte on the wire

	// ----------------------------------------
	// Slave address byte layout
	// ----------------------------------------
	localparam logic [3:0] DEVICE_TYPE = 4'hA; // Fixed device-type code
	localparam int SA_TYPE_LSB = 4; // Type code sits in bits 7..4
	localparam int SA_SEL_LSB = 2; // Select bits sit in bits 3..2
	localparam int SA_TOP_BIT = 1; // Top word address bit
	localparam int SA_DIR_BIT = 0; // 0 write, 1 read
	localparam logic [4:0] HS_CODE = 5'h01; // High-speed master code, top five bits

	// ----------------------------------------
	// Timing of the master's divider
	// ----------------------------------------
	localparam int SYS_PERIOD_NS = 10; // System clock period
	localparam int SCL_PERIOD_NS = 2500; // Serial clock period made by the master
	// Quarter period rounded up, so the serial clock never runs fast
	localparam int SCL_QUARTER_CYC = (SCL_PERIOD_NS + 4 * SYS_PERIOD_NS - 1)
		/ (4 * SYS_PERIOD_NS);

	// ----------------------------------------
	// Master byte-level operations
	// ----------------------------------------
	typedef enum logic [1:0] {
		OP_START = 2'h0,
		OP_STOP = 2'h1,
		OP_WRITE = 2'h2,
		OP_READ = 2'h3
	} op_t;

endpackage

// *** logic/i2c_link_if.sv ***
// Two-wire link between the memory and its bus master
`timescale 1ns/1ps
interface i2c_link_if;
	logic hostSclOe; // Master pulls the clock low
	logic hostSdaOe; // Master pulls data low
	logic devSdaOe; // Memory pulls data low
	logic hostWp; // Write protect level driven by the master
	logic scl; // Resolved clock wire
	logic sda; // Resolved data wire
	logic wp; // Resolved write protect wire

	// Clock and data are open-drain lines with pull-ups, low while anyone pulls; protect follows the master
	assign scl = ~hostSclOe;
	assign sda = ~(hostSdaOe | devSdaOe);
	assign wp = hostWp;

	modport host (output hostSclOe, output hostSdaOe, output hostWp, input scl, input sda);
	modport device (output devSdaOe, input scl, input sda, input wp);
endinterface

// *** logic/fram_i2c_master.sv ***
// Byte-level two-wire bus master that drives the memory link
`timescale 1ns/1ps
module fram_i2c_master #(
	parameter int QUARTER = fram_link_pkg::SCL_QUARTER_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Link
	i2c_link_if.host link,
	// Command side
	input wire logic cmdValid,
	output logic cmdReady,
	input fram_link_pkg::op_t cmdOp,
	input wire logic [7:0] cmdData,
	input wire logic cmdNack,
	input wire logic wpLevel,
	// Response side
	output logic rspValid,
	output logic [7:0] rspData,
	output logic rspNack
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef enum logic [3:0] {
		H_IDLE = 4'h1,
		H_START = 4'h2,
		H_STOP = 4'h4,
		H_BITS = 4'h8
	} host_state_t;

	typedef struct packed {
		host_state_t state;
		logic [1:0] quarter; // Quarter of the current bit
		logic [15:0] cnt; // Divider count
		logic [3:0] bitIdx; // Bit of nine in a byte
		logic [8:0] tx; // Data plus acknowledge slot
		logic [8:0] rx; // Sampled bits
		logic sclLow;
		logic sdaLow;
		logic ready;
		logic rspV;
		logic [7:0] rspD;
		logic rspN;
		logic wp;
		logic busFree; // No start since the last stop
		logic sda1; // Synchroniser first stage
		logic sda2; // Synchroniser second stage
	} host_reg_t;

	localparam host_reg_t RESET_VAL = '{state: H_IDLE, ready: 1'b1, busFree: 1'b1,
		sda1: 1'b1, sda2: 1'b1, default: '0};
	localparam logic [15:0] QMAX = 16'(QUARTER - 1);

	host_reg_t r_ff;
	host_reg_t nxt_r;
	logic tick; // End of a quarter
	logic [8:0] rxNext; // Sample with the current bit shifted in

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		nxt_r = r_ff;
		tick = (r_ff.cnt == QMAX);
		rxNext = {r_ff.rx[7:0], r_ff.sda2};
		nxt_r.rspV = 1'b0;
		nxt_r.sda1 = link.sda;
		nxt_r.sda2 = r_ff.sda1;
		nxt_r.cnt = tick ? 16'h0000 : 16'(r_ff.cnt + 16'h0001);
		if (tick) begin
			nxt_r.quarter = 2'(r_ff.quarter + 2'h1);
		end
		case (r_ff.state)
			H_IDLE: begin
				nxt_r.cnt = 16'h0000;
				nxt_r.quarter = 2'h0;
				nxt_r.bitIdx = 4'h0;
				if (cmdValid && r_ff.ready) begin
					nxt_r.ready = 1'b0;
					case (cmdOp)
						fram_link_pkg::OP_START: begin
							nxt_r.state = H_START;
							// Protect level held from start to stop RQ14
							if (r_ff.busFree) begin
								nxt_r.wp = wpLevel;
							end
							nxt_r.busFree = 1'b0;
						end
						fram_link_pkg::OP_STOP: nxt_r.state = H_STOP;
						fram_link_pkg::OP_WRITE: begin
							// Release the line in the acknowledge slot RQ5
							nxt_r.tx = {cmdData, 1'b1};
							nxt_r.state = H_BITS;
						end
						default: begin
							// High ninth bit ends a read RQ19
							nxt_r.tx = {8'hFF, cmdNack};
							nxt_r.state = H_BITS;
						end
					endcase
				end
			end
			H_START: if (tick) begin
				// Data falls while clock is high RQ2
				case (r_ff.quarter)
					2'h0: nxt_r.sdaLow = 1'b0;
					2'h1: nxt_r.sclLow = 1'b0;
					2'h2: nxt_r.sdaLow = 1'b1;
					default: begin
						nxt_r.sclLow = 1'b1;
						nxt_r.state = H_IDLE;
						nxt_r.ready = 1'b1;
						nxt_r.rspV = 1'b1;
					end
				endcase
			end
			H_STOP: if (tick) begin
				// Data rises while clock is high RQ3
				case (r_ff.quarter)
					2'h0: nxt_r.sdaLow = 1'b1;
					2'h1: nxt_r.sclLow = 1'b0;
					2'h2: nxt_r.sdaLow = 1'b0;
					default: begin
						nxt_r.state = H_IDLE;
						nxt_r.ready = 1'b1;
						nxt_r.rspV = 1'b1;
						nxt_r.busFree = 1'b1;
					end
				endcase
			end
			H_BITS: if (tick) begin
				// Nine clocks per byte RQ4
				case (r_ff.quarter)
					2'h0: nxt_r.sdaLow = ~r_ff.tx[8];
					2'h1: nxt_r.sclLow = 1'b0;
					2'h2: ;
					default: begin
						nxt_r.rx = rxNext;
						nxt_r.sclLow = 1'b1;
						nxt_r.tx = {r_ff.tx[7:0], 1'b1};
						nxt_r.bitIdx = 4'(r_ff.bitIdx + 4'h1);
						if (r_ff.bitIdx == 4'h8) begin
							// Data left as is: moving it with the clock fall could fake a stop
							nxt_r.state = H_IDLE;
							nxt_r.ready = 1'b1;
							nxt_r.rspV = 1'b1;
							nxt_r.rspD = rxNext[8:1];
							nxt_r.rspN = rxNext[0];
						end
					end
				endcase
			end
			default: nxt_r = RESET_VAL;
		endcase
	end

	// ----------------------------------------
	// Registers, synchronous reset
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			r_ff <= RESET_VAL;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// Outputs come straight from the state register
	assign link.hostSclOe = r_ff.sclLow;
	assign link.hostSdaOe = r_ff.sdaLow;
	assign link.hostWp = r_ff.wp;
	assign cmdReady = r_ff.ready;
	assign rspValid = r_ff.rspV;
	assign rspData = r_ff.rspD;
	assign rspNack = r_ff.rspN;

endmodule

// *** logic/fram_i2c_slave.sv ***
// Serial memory slave end of the two-wire link, clocked by the link clock
//
// Contract
// RQ1: Sample on clock rise, drive on clock fall
// RQ2: Start condition always watched, commands need it
// RQ3: Data rising with clock high ends command
// RQ4: Bytes are eight bits plus acknowledge
// RQ5: Sender releases; receiver pulls low ninth clock
// RQ6: Acknowledge own slave address low
// RQ7: Acknowledge every word address and data byte
// RQ8: Keep sending on acknowledge, else go idle
// RQ9: Respond only to matching device-type code
// RQ10: Select bits must match select pins
// RQ11: Next address bit is top word bit
// RQ12: Lowest address bit: 0 write, 1 read
// RQ13: Write protect high blocks all writes
// RQ14: Master holds protect steady start to stop
// RQ15: Byte write: start, address, two words, data
// RQ16: Consecutive writes increment address, wrap around
// RQ17: Overlong page write overwrites from first byte
// RQ18: Random read ignores top bit in read
// RQ19: Master ends read with high acknowledge
// RQ20: Sequential read advances address, wraps around
// RQ21: Bare read returns address after last
// RQ22: Pointer undefined after power-up; not relied upon
// RQ23: High-speed command holds until next stop
// RQ24: Address is top bit, high, low bytes
`timescale 1ns/1ps
module fram_i2c_slave (
	// Reset
	input wire logic resetn,
	// Link
	i2c_link_if.device link,
	// Straps
	input wire logic [1:0] deviceSelectPins,
	// Status
	output logic hsMode,
	output logic selected
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef enum logic [5:0] {
		D_IDLE = 6'h01, // Ignore the bus until a start
		D_SLAVE = 6'h02, // Receiving the slave address
		D_WHI = 6'h04, // Receiving the high word address byte
		D_WLO = 6'h08, // Receiving the low word address byte
		D_WDATA = 6'h10, // Receiving write data
		D_TX = 6'h20 // Sending read data
	} dev_state_t;

	typedef struct packed {
		dev_state_t state;
		logic [3:0] bitCnt; // Bits 0..7, then 8 for acknowledge
		logic [7:0] shift; // Incoming byte
		logic [7:0] tx; // Outgoing byte, msb next
		logic [fram_link_pkg::ADDR_W-1:0] addr; // Internal address pointer
		logic wordAddressTopBit; // Top word bit from the slave address
		logic ackNow; // Pull low in the coming acknowledge slot
		logic hs;
		logic sel;
		logic startSeen; // Copy of the start toggle
		logic stopSeen; // Copy of the stop toggle
		logic [1:0] selSync1;
		logic [1:0] selSync2;
		logic wpSync1;
		logic wpSync2;
	} dev_reg_t;

	// Pointer resets to zero, but software must not rely on it
	localparam dev_reg_t RESET_VAL = '{state: D_IDLE, default: '0}; // RQ22

	dev_reg_t r_ff;
	dev_reg_t nxt_r;
	logic startTgl_ff; // Flips on every start condition
	logic stopTgl_ff; // Flips on every stop condition
	logic sdaLow_ff; // Open-drain pull, changed on clock fall
	logic wantLow; // Value for the next falling edge
	logic startPend; // Start seen since last clock rise
	logic stopPend; // Stop seen since last clock rise
	logic [7:0] byteIn; // Byte completed by the current bit
	logic [fram_link_pkg::ADDR_W-1:0] addrInc; // Pointer plus one, wrapping
	logic memWe; // Store write data this edge
	logic [7:0] mem [fram_link_pkg::MEM_DEPTH]; // Storage array

	// ----------------------------------------
	// Start and stop detection
	// ----------------------------------------
	// Edges of data while the clock is high mark frame bounds.
	// The toggles are read on the next clock rise; the protocol's
	// hold times keep them settled by then, so no extra stages are used,
	// which would cost bits of the following byte.
	always_ff @(negedge link.sda or negedge resetn) begin
		if (!resetn) begin
			startTgl_ff <= 1'b0;
		end else if (link.scl) begin
			startTgl_ff <= ~startTgl_ff; // RQ2
		end
	end

	always_ff @(posedge link.sda or negedge resetn) begin
		if (!resetn) begin
			stopTgl_ff <= 1'b0;
		end else if (link.scl) begin
			stopTgl_ff <= ~stopTgl_ff; // RQ3
		end
	end

	// ----------------------------------------
	// Bit and byte sequencing on clock rise
	// ----------------------------------------
	always_comb begin
		nxt_r = r_ff;
		memWe = 1'b0;
		startPend = (startTgl_ff != r_ff.startSeen);
		stopPend = (stopTgl_ff != r_ff.stopSeen);
		byteIn = {r_ff.shift[6:0], link.sda};
		addrInc = fram_link_pkg::ADDR_W'(r_ff.addr + 1'b1);
		// Straps and protect pass two stages before use
		nxt_r.selSync1 = deviceSelectPins;
		nxt_r.selSync2 = r_ff.selSync1;
		nxt_r.wpSync1 = link.wp;
		nxt_r.wpSync2 = r_ff.wpSync1;
		if (startPend) begin
			// This rise carries the first address bit RQ2
			nxt_r.startSeen = startTgl_ff;
			nxt_r.stopSeen = stopTgl_ff;
			if (stopPend) begin
				nxt_r.hs = 1'b0; // RQ23
			end
			nxt_r.state = D_SLAVE;
			nxt_r.bitCnt = 4'h1;
			nxt_r.shift = {7'h00, link.sda};
			nxt_r.ackNow = 1'b0;
			nxt_r.sel = 1'b0;
		end else if (stopPend) begin
			// Frame ended; go idle, drop select, acknowledge and fast mode RQ3
			nxt_r.stopSeen = stopTgl_ff;
			nxt_r.hs = 1'b0; // RQ23
			nxt_r.state = D_IDLE;
			nxt_r.ackNow = 1'b0;
			nxt_r.sel = 1'b0;
		end else begin
			case (r_ff.state)
				D_IDLE: ;
				D_TX: begin
					if (r_ff.bitCnt < 4'h7) begin
						nxt_r.tx = {r_ff.tx[6:0], 1'b0};
						nxt_r.bitCnt = 4'(r_ff.bitCnt + 4'h1);
					end else if (r_ff.bitCnt == 4'h7) begin
						nxt_r.bitCnt = 4'h8; // Release for master acknowledge RQ5
					end else begin
						// Each sent byte advances the pointer RQ21
						nxt_r.addr = addrInc;
						if (!link.sda) begin
							// Acknowledged: next byte, wrapping RQ8 RQ20
							nxt_r.tx = mem[addrInc];
							nxt_r.bitCnt = 4'h0;
						end else begin
							nxt_r.state = D_IDLE; // RQ8
							nxt_r.sel = 1'b0;
						end
					end
				end
				default: begin
					if (r_ff.bitCnt < 4'h7) begin
						nxt_r.shift = byteIn;
						nxt_r.bitCnt = 4'(r_ff.bitCnt + 4'h1);
					end else if (r_ff.bitCnt == 4'h7) begin
						// Eighth bit in; decide the acknowledge RQ4
						nxt_r.shift = byteIn;
						nxt_r.bitCnt = 4'h8;
						case (r_ff.state)
							D_SLAVE: begin
								if (byteIn[7:3] == fram_link_pkg::HS_CODE) begin
									// Master code is never acknowledged RQ23
									nxt_r.hs = 1'b1;
									nxt_r.state = D_IDLE;
								end else if (byteIn[7:fram_link_pkg::SA_TYPE_LSB] ==
									fram_link_pkg::DEVICE_TYPE && // RQ9
									byteIn[fram_link_pkg::SA_SEL_LSB +: 2] ==
									r_ff.selSync2) begin // RQ10
									nxt_r.ackNow = 1'b1; // RQ6
									nxt_r.sel = 1'b1;
									nxt_r.wordAddressTopBit = byteIn[fram_link_pkg::SA_TOP_BIT]; // RQ11
								end else begin
									nxt_r.state = D_IDLE;
								end
							end
							D_WDATA: begin
								nxt_r.ackNow = 1'b1; // RQ7
								memWe = ~r_ff.wpSync2; // RQ13
								// Store, then step and wrap RQ16 RQ17
								nxt_r.addr = addrInc;
							end
							default: nxt_r.ackNow = 1'b1; // RQ7
						endcase
					end else begin
						// Acknowledge clock done; act on the byte
						nxt_r.ackNow = 1'b0;
						nxt_r.bitCnt = 4'h0;
						case (r_ff.state)
							D_SLAVE: begin
								if (r_ff.shift[fram_link_pkg::SA_DIR_BIT]) begin
									// Read: top bit ignored, pointer kept RQ12 RQ18 RQ21
									nxt_r.state = D_TX;
									nxt_r.tx = mem[r_ff.addr];
								end else begin
									nxt_r.state = D_WHI; // RQ12 RQ15
								end
							end
							D_WHI: begin
								nxt_r.addr = {r_ff.wordAddressTopBit, r_ff.shift, r_ff.addr[7:0]}; // RQ24
								nxt_r.state = D_WLO;
							end
							D_WLO: begin
								nxt_r.addr[7:0] = r_ff.shift; // RQ24
								nxt_r.state = D_WDATA;
							end
							default: ;
						endcase
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Rising-edge registers and storage
	// ----------------------------------------
	always_ff @(posedge link.scl or negedge resetn) begin
		if (!resetn) begin
			r_ff <= RESET_VAL;
		end else begin
			r_ff <= nxt_r; // RQ1
		end
	end

	// Storage has no reset; contents are undefined until written
	always_ff @(posedge link.scl) begin
		if (memWe) begin
			mem[r_ff.addr] <= byteIn;
		end
	end

	// ----------------------------------------
	// Data output on clock fall
	// ----------------------------------------
	always_comb begin
		// Pull for acknowledge, or for a zero data bit RQ5
		wantLow = (r_ff.ackNow && r_ff.bitCnt == 4'h8) ||
			(r_ff.state == D_TX && r_ff.bitCnt < 4'h8 && !r_ff.tx[7]);
	end

	always_ff @(negedge link.scl or negedge resetn) begin
		if (!resetn) begin
			sdaLow_ff <= 1'b0;
		end else begin
			sdaLow_ff <= wantLow; // RQ1
		end
	end

	assign link.devSdaOe = sdaLow_ff;
	assign hsMode = r_ff.hs;
	assign selected = r_ff.sel;

endmodule

// *** testbench/fram_link_asserts.sv ***
// Concurrent checks on the two-wire link between master and memory
`timescale 1ns/1ps
module fram_link_asserts (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Link wires
	input wire logic scl,
	input wire logic sda,
	input wire logic devSdaOe,
	// Memory straps and status
	input wire logic [1:0] deviceSelectPins,
	input wire logic hsMode,
	input wire logic selected
);
	// ----------------------------------------
	// Bus event tracking
	// ----------------------------------------
	logic sclQ; // Clock one sample ago
	logic sdaQ; // Data one sample ago
	logic [3:0] bitCnt; // Rises since start, nine per byte
	logic [7:0] shReg; // Bits of the current byte
	logic firstByte; // Address byte in progress
	logic addrOk; // Address matched this memory
	logic dirRead; // Read direction latched
	logic quiet; // Master refused a read byte
	logic afterStop; // Stop seen, no rise since
	logic sclRise;
	logic startEv;
	logic stopEv;
	logic ninth;
	logic match;
	assign sclRise = scl & ~sclQ;
	assign startEv = scl & sclQ & sdaQ & ~sda; // Data falls, clock high
	assign stopEv = scl & sclQ & ~sdaQ & sda; // Data rises, clock high
	assign ninth = sclRise && (bitCnt == 4'h8);
	assign match = (shReg[7:4] == fram_link_pkg::DEVICE_TYPE) && (shReg[3:2] == deviceSelectPins);

	// Oversampling is safe: the link moves far slower than the system clock
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			sclQ <= 1'b1;
			sdaQ <= 1'b1;
			bitCnt <= 4'h0;
			shReg <= 8'h00;
			firstByte <= 1'b1;
			addrOk <= 1'b0;
			dirRead <= 1'b0;
			quiet <= 1'b0;
			afterStop <= 1'b0;
		end else begin
			sclQ <= scl;
			sdaQ <= sda;
			afterStop <= stopEv | (afterStop & ~sclRise);
			if (startEv) begin
				// Any start restarts byte framing
				bitCnt <= 4'h0;
				firstByte <= 1'b1;
				quiet <= 1'b0;
			end else if (sclRise) begin
				bitCnt <= ninth ? 4'h0 : bitCnt + 4'h1;
				if (!ninth) begin
					shReg <= {shReg[6:0], sda};
				end
				if (ninth && firstByte) begin
					addrOk <= match;
					dirRead <= shReg[0];
					firstByte <= 1'b0;
				end
				if (ninth && !firstByte && addrOk && dirRead && sda) begin
					quiet <= 1'b1;
				end
			end
		end
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	sequence sAddrEnd;
		ninth && firstByte;
	endsequence

	a_dev_on_fall: assert property ($changed(devSdaOe) |-> $fell(scl))
		else $error("memory data drive moved away from a clock fall");
	a_addr_ack: assert property (sAddrEnd |-> devSdaOe == match)
		else $error("address acknowledge does not follow the address match");
	a_word_ack: assert property (ninth && !firstByte && addrOk && !dirRead |-> devSdaOe)
		else $error("written byte not acknowledged");
	a_read_release: assert property (ninth && !firstByte && addrOk && dirRead |-> !devSdaOe)
		else $error("memory holds data during master acknowledge");
	a_nack_idle: assert property (quiet |-> !devSdaOe)
		else $error("memory drives data after a refused byte");
	a_foreign_quiet: assert property (!firstByte && !addrOk |-> !devSdaOe && !selected)
		else $error("memory answers a foreign address");
	a_sel_rise: assert property (sAddrEnd ##0 match |-> ##[0:4] selected)
		else $error("selected not raised on own address");
	a_hs_entry: assert property (sAddrEnd ##0 (shReg[7:3] == fram_link_pkg::HS_CODE)
		|-> ##[0:40] hsMode)
		else $error("fast mode not entered after its code");
	a_hs_exit: assert property (sclRise && afterStop |-> ##[1:3] !hsMode)
		else $error("fast mode kept past a stop");
endmodule

// *** testbench/i2c_fram_slave_interface_test.sv ***
// Master and memory ends joined over the link, driven by command sequences
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin mismatches++; \
	$display("unexpected %s: expected %h, seen %h", nm, (exp), (got)); end end
module i2c_fram_slave_interface_test;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam logic [1:0] SEL = 2'h2; // Strap of the memory
	localparam logic [3:0] TYPE = fram_link_pkg::DEVICE_TYPE;
	logic sys_clk = 1'b0;
	logic resetn = 1'b1;
	logic cmdValid = 1'b0;
	fram_link_pkg::op_t cmdOp = fram_link_pkg::OP_START;
	logic [7:0] cmdData = 8'h00;
	logic cmdNack = 1'b0;
	logic wpLevel = 1'b0; // Protect low unless a test sets it
	logic cmdReady;
	logic rspValid;
	logic [7:0] rspData;
	logic rspNack;
	logic hsMode;
	logic selected;
	int mismatches = 0;
	int n_tests = 0;

	i2c_link_if link();
	// Short quarter keeps the run brief
	fram_i2c_master #(.QUARTER(3)) i_fram_i2c_master (.sys_clk(sys_clk), .resetn(resetn),
		.link(link), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
		.cmdData(cmdData), .cmdNack(cmdNack), .wpLevel(wpLevel), .rspValid(rspValid),
		.rspData(rspData), .rspNack(rspNack));
	fram_i2c_slave i_fram_i2c_slave (.resetn(resetn), .link(link), .deviceSelectPins(SEL),
		.hsMode(hsMode), .selected(selected));
	fram_link_asserts i_fram_link_asserts (.sys_clk(sys_clk), .resetn(resetn),
		.scl(link.scl), .sda(link.sda), .devSdaOe(link.devSdaOe),
		.deviceSelectPins(SEL), .hsMode(hsMode), .selected(selected));

	// 100 MHz system clock
	always #5 sys_clk = ~sys_clk;

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic close_out();
		$display("checks %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// One byte-level command; raised only while ready, so the next edge takes it
	task automatic op(input fram_link_pkg::op_t o, input logic [7:0] d, input logic nk);
		int i;
		@(negedge sys_clk);
		while (cmdReady !== 1'b1) @(negedge sys_clk);
		cmdValid = 1'b1;
		cmdOp = o;
		cmdData = d;
		cmdNack = nk;
		@(negedge sys_clk);
		cmdValid = 1'b0;
		for (i = 0; i < 2000 && rspValid !== 1'b1; i++) @(negedge sys_clk);
		if (i == 2000) begin
			mismatches++;
			$display("unexpected response wait: expected 1, seen 0");
			close_out();
		end
	endtask

	task automatic wrByte(input logic [7:0] d);
		op(fram_link_pkg::OP_WRITE, d, 1'b0);
		`CHK("write ack", 1'b0, rspNack)
	endtask

	// Start, write address, both word bytes
	task automatic addrPhase(input logic [16:0] a);
		op(fram_link_pkg::OP_START, 8'h00, 1'b0);
		wrByte({TYPE, SEL, a[16], 1'b0});
		wrByte(a[15:8]);
		wrByte(a[7:0]);
	endtask

	task automatic writeSeq(input logic [16:0] a, input int n, input logic [7:0] d0);
		int i;
		addrPhase(a);
		for (i = 0; i < n; i++) wrByte(d0 + 8'(i));
		op(fram_link_pkg::OP_STOP, 8'h00, 1'b0);
	endtask

	// Top bit is sent inverted in the read byte, since it must be ignored
	task automatic readSeq(input logic [16:0] a, input logic rnd, input int n,
		input logic [7:0] d0);
		int i;
		if (rnd) addrPhase(a);
		op(fram_link_pkg::OP_START, 8'h00, 1'b0);
		wrByte({TYPE, SEL, ~a[16], 1'b1});
		for (i = 0; i < n; i++) begin
			op(fram_link_pkg::OP_READ, 8'h00, i == n - 1);
			`CHK("read data", d0 + 8'(i), rspData)
		end
		op(fram_link_pkg::OP_STOP, 8'h00, 1'b0);
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		int i;
		logic [7:0] bad [3];
		// A real falling reset edge, so the memory's asynchronous reset acts
		#1;
		resetn = 1'b0;
		bad[0] = {4'hB, SEL, 2'h0};
		bad[1] = {TYPE, ~SEL, 2'h0};
		bad[2] = {TYPE, 2'h0, 2'h1};
		repeat (8) @(negedge sys_clk);
		resetn = 1'b1;
		// Pointer is set by addressed writes before any bare read
		writeSeq(17'h1FFFE, 3, 8'h5A);
		readSeq(17'h1FFFE, 1'b1, 3, 8'h5A);
		writeSeq(17'h10040, 2, 8'h3C);
		readSeq(17'h10040, 1'b1, 1, 8'h3C);
		// Fast-mode code is refused but switches the mode on
		op(fram_link_pkg::OP_START, 8'h00, 1'b0);
		op(fram_link_pkg::OP_WRITE, {fram_link_pkg::HS_CODE, 3'h5}, 1'b0);
		`CHK("code nack", 1'b1, rspNack)
		`CHK("fast mode", 1'b1, hsMode)
		op(fram_link_pkg::OP_STOP, 8'h00, 1'b0);
		// Bare read continues after the last byte read
		readSeq(17'h00000, 1'b0, 1, 8'h3D);
		`CHK("fast mode after stop", 1'b0, hsMode)
		// Protected write is dropped
		wpLevel = 1'b1;
		writeSeq(17'h10040, 1, 8'hC3);
		wpLevel = 1'b0;
		readSeq(17'h10040, 1'b1, 1, 8'h3C);
		// Wrong type code or strap gets no acknowledge
		for (i = 0; i < 3; i++) begin
			op(fram_link_pkg::OP_START, 8'h00, 1'b0);
			op(fram_link_pkg::OP_WRITE, bad[i], 1'b0);
			`CHK("foreign nack", 1'b1, rspNack)
			op(fram_link_pkg::OP_STOP, 8'h00, 1'b0);
		end
		close_out();
	end

	// Watchdog, more than eight times the expected run
	initial begin
		repeat (40000) @(posedge sys_clk);
		mismatches++;
		$display("unexpected run length: expected end before 40000 cycles, seen limit");
		close_out();
	end
endmodule
